// [hdl/osf_cfg.svh]
`ifndef OSF_CFG_SVH
`define OSF_CFG_SVH
// converter word and channel count
`define OSF_SAMPLE_W 18
`define OSF_CHANNELS 8
`define OSF_CHAN_W 3
// accumulator holds 64 samples of 18 bits
`define OSF_ACC_W 24
`define OSF_SET_W 7
// ratio select codes
`define OSF_SEL_NONE 3'h0
`define OSF_SEL_INVALID 3'h7
`define OSF_ALL_CHANNELS 8'hFF
`define OSF_LAST_CHAN 3'h7
`define OSF_SEL_MAX 3'h6
// fastest sample period at 500 ksps, and clock period
`define OSF_SAMPLE_NS 2000
`define OSF_CLK_NS 50
// least time, rounded up to whole cycles
`define OSF_SAMPLE_CYC ((`OSF_SAMPLE_NS + `OSF_CLK_NS - 1) / `OSF_CLK_NS)
`define OSF_TMR_W 6
// saturating trigger spacing counter used by the checks
`define OSF_SINCE_W 8
`define OSF_SINCE_MAX 8'hFF
`define OSF_SINCE_ONE 8'h01
// result fifo shape
`define OSF_FIFO_DEPTH 4
`define OSF_FIFO_AW 2
`endif

// [hdl/osf_pkg.sv]
package osf_pkg;
  // filter sequencer states, gray coded along idle-conv-out
  typedef enum logic [1:0]
  {
    OSF_IDLE = 2'h0,
    OSF_CONV = 2'h1,
    OSF_OUT = 2'h3
  } osf_state_t;
endpackage

// [hdl/osf_filter.sv]
`timescale 1ns/1ns
`include "osf_cfg.svh"

// small result fifo, valid/ready on both sides
module osf_fifo
#(
  parameter int W = `OSF_SAMPLE_W + `OSF_CHAN_W,
  parameter int D = `OSF_FIFO_DEPTH,
  parameter int AW = `OSF_FIFO_AW
)
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  logic [W-1:0] mem [D]; // storage words
  logic [AW-1:0] wr_reg, wr_next; // write pointer
  logic [AW-1:0] rd_reg, rd_next; // read pointer
  logic [AW:0] cnt_reg, cnt_next; // words held
  logic push, pop;

  assign in_ready_o = (cnt_reg < (AW+1)'(D));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o = mem[rd_reg];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // pointer and count update
  always_comb
  begin
    wr_next = wr_reg;
    rd_next = rd_reg;
    cnt_next = cnt_reg;
    if (push)
      wr_next = (wr_reg == AW'(D - 1)) ? '0 : AW'(wr_reg + 1'b1);
    if (pop)
      rd_next = (rd_reg == AW'(D - 1)) ? '0 : AW'(rd_reg + 1'b1);
    case ({push, pop})
      2'h2: cnt_next = (AW+1)'(cnt_reg + 1'b1);
      2'h1: cnt_next = (AW+1)'(cnt_reg - 1'b1);
      default: cnt_next = cnt_reg;
    endcase
  end

  // registers
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // data array, no reset needed
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem[wr_reg] <= in_data_i;
  end
endmodule // osf_fifo

module osf_filter
  import osf_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [2:0] oversample_ratio_select_i,
  input wire logic group_a_convert_start_i,
  input wire logic group_b_convert_start_i,
  input wire logic sample_valid_i,
  input wire logic [`OSF_CHAN_W-1:0] sample_chan_i,
  input wire logic [`OSF_SAMPLE_W-1:0] sample_data_i,
  input wire logic result_ready_i,
  output logic sample_trigger_o,
  output logic busy_o,
  output logic result_valid_o,
  output logic [`OSF_CHAN_W-1:0] result_chan_o,
  output logic [`OSF_SAMPLE_W-1:0] result_data_o
);
  localparam int FW = `OSF_SAMPLE_W + `OSF_CHAN_W;
  localparam int PACE_MIN = `OSF_SAMPLE_CYC; // least cycles between triggers
  localparam int PACE_MAX = `OSF_SAMPLE_CYC + 1; // latest internal trigger

  // divide an accumulated sum by 2**sel, sign kept
  function automatic logic [`OSF_SAMPLE_W-1:0] avg_f(
    input logic signed [`OSF_ACC_W-1:0] sum,
    input logic [2:0] sel);
    logic signed [`OSF_ACC_W-1:0] t;
    t = sum >>> sel;
    return t[`OSF_SAMPLE_W-1:0];
  endfunction

  osf_state_t state_reg, state_next; // sequencer
  logic start_prev_reg, start_prev_next; // last start level
  logic [2:0] sel_reg, sel_next; // ratio held for the set
  logic [`OSF_SET_W-1:0] set_reg, set_next; // sample round
  logic [`OSF_CHANNELS-1:0] got_reg, got_next; // channels seen
  logic [`OSF_TMR_W-1:0] tmr_reg, tmr_next; // internal pacing
  logic trig_reg, trig_next; // sample trigger out
  logic busy_reg, busy_next; // set in progress
  logic [`OSF_CHAN_W-1:0] pch_reg, pch_next; // channel pushed
  logic signed [`OSF_ACC_W-1:0] acc_reg [`OSF_CHANNELS]; // sums
  logic signed [`OSF_ACC_W-1:0] acc_next [`OSF_CHANNELS];
  logic rv_reg, rv_next; // result valid
  logic [FW-1:0] rd_reg, rd_next; // result chan and data
  logic start_both, host_edge, last_set;
  logic [`OSF_SET_W-1:0] set_last;
  logic push_v, push_r, pop_v, pop_r;
  logic [FW-1:0] push_d, pop_d;

  // both groups must start together; the host ties them
  assign start_both = group_a_convert_start_i && group_b_convert_start_i;
  assign host_edge = start_both && !start_prev_reg;
  assign set_last = `OSF_SET_W'((`OSF_SET_W'(1) << sel_reg) - `OSF_SET_W'(1));
  assign last_set = (set_reg == set_last);
  assign push_v = (state_reg == OSF_OUT);
  assign push_d = {pch_reg, avg_f(acc_reg[pch_reg], sel_reg)};

  // sequencer, pacing and accumulation
  always_comb
  begin
    state_next = state_reg;
    start_prev_next = start_both;
    sel_next = sel_reg;
    set_next = set_reg;
    got_next = got_reg;
    tmr_next = (tmr_reg != '0) ? `OSF_TMR_W'(tmr_reg - 1'b1) : tmr_reg;
    trig_next = 1'b0;
    pch_next = pch_reg;
    acc_next = acc_reg;
    case (state_reg)
      // invalid code takes no sample
      OSF_IDLE:
        if (host_edge && oversample_ratio_select_i != `OSF_SEL_INVALID)
        begin
          trig_next = 1'b1;
          sel_next = oversample_ratio_select_i;
          set_next = '0;
          got_next = '0;
          tmr_next = `OSF_TMR_W'(`OSF_SAMPLE_CYC - 1);
          state_next = OSF_CONV;
        end
      OSF_CONV:
      begin
        // first round loads, later rounds add
        if (sample_valid_i)
        begin
          got_next = got_reg | (`OSF_CHANNELS'(1) << sample_chan_i);
          if (set_reg == '0)
            acc_next[sample_chan_i] = `OSF_ACC_W'(signed'(sample_data_i));
          else
            acc_next[sample_chan_i] = acc_reg[sample_chan_i]
              + `OSF_ACC_W'(signed'(sample_data_i));
        end
        if (got_reg == `OSF_ALL_CHANNELS)
        begin
          if (last_set)
          begin
            pch_next = '0;
            state_next = OSF_OUT;
          end
          else if (tmr_reg == '0)
          begin
            // next round without host involvement
            trig_next = 1'b1;
            set_next = `OSF_SET_W'(set_reg + 1'b1);
            got_next = '0;
            tmr_next = `OSF_TMR_W'(`OSF_SAMPLE_CYC - 1);
          end
        end
      end
      // one word per channel, stalled by the fifo
      OSF_OUT:
        if (push_r)
        begin
          pch_next = `OSF_CHAN_W'(pch_reg + 1'b1);
          if (pch_reg == `OSF_LAST_CHAN)
            state_next = OSF_IDLE;
        end
      default: state_next = OSF_IDLE;
    endcase
    busy_next = (state_next != OSF_IDLE);
  end

  // sequencer registers
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_reg <= OSF_IDLE;
      start_prev_reg <= 1'b0;
      sel_reg <= `OSF_SEL_NONE;
      set_reg <= '0;
      got_reg <= '0;
      tmr_reg <= '0;
      trig_reg <= 1'b0;
      busy_reg <= 1'b0;
      pch_reg <= '0;
      for (int i = 0; i < `OSF_CHANNELS; i++)
        acc_reg[i] <= '0;
    end
    else
    begin
      state_reg <= state_next;
      start_prev_reg <= start_prev_next;
      sel_reg <= sel_next;
      set_reg <= set_next;
      got_reg <= got_next;
      tmr_reg <= tmr_next;
      trig_reg <= trig_next;
      busy_reg <= busy_next;
      pch_reg <= pch_next;
      acc_reg <= acc_next;
    end
  end

  // results queue between filter and reader
  osf_fifo #(.W(FW), .D(`OSF_FIFO_DEPTH), .AW(`OSF_FIFO_AW)) u_fifo
  (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .in_valid_i(push_v),
    .in_ready_o(push_r),
    .in_data_i(push_d),
    .out_valid_o(pop_v),
    .out_ready_i(pop_r),
    .out_data_o(pop_d)
  );
  assign pop_r = !rv_reg || result_ready_i;
  // registered output stage
  always_comb
  begin
    rv_next = rv_reg;
    rd_next = rd_reg;
    if (pop_r)
    begin
      rv_next = pop_v;
      rd_next = pop_v ? pop_d : rd_reg;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rv_reg <= 1'b0;
      rd_reg <= '0;
    end
    else
    begin
      rv_reg <= rv_next;
      rd_reg <= rd_next;
    end
  end

  assign sample_trigger_o = trig_reg;
  assign busy_o = busy_reg;
  assign result_valid_o = rv_reg;
  assign result_chan_o = rd_reg[FW-1:`OSF_SAMPLE_W];
  assign result_data_o = rd_reg[`OSF_SAMPLE_W-1:0];

  // check helpers: cycles since the last trigger, triggers in this set
  logic [`OSF_SINCE_W-1:0] since_reg; // saturates, never wraps
  logic [`OSF_SET_W-1:0] trigs_reg; // cleared while idle
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      since_reg <= `OSF_SINCE_MAX;
      trigs_reg <= '0;
    end
    else
    begin
      since_reg <= trig_reg ? `OSF_SINCE_ONE
        : ((since_reg == `OSF_SINCE_MAX) ? since_reg : since_reg + `OSF_SINCE_ONE);
      trigs_reg <= (state_reg == OSF_IDLE) ? '0 : `OSF_SET_W'(trigs_reg + trig_reg);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  invalid_sel_a: assert property (
    (state_reg == OSF_IDLE && host_edge && oversample_ratio_select_i == `OSF_SEL_INVALID)
    |=> !sample_trigger_o && !busy_o)
    else $error("invalid ratio started a set");
  pace_gap_a: assert property (
    (sample_trigger_o && $past(state_reg) == OSF_CONV) |-> since_reg >= PACE_MIN)
    else $error("internal trigger faster than sample period");
  host_start_a: assert property (
    (state_reg == OSF_IDLE && host_edge && oversample_ratio_select_i != `OSF_SEL_INVALID)
    |=> sample_trigger_o ##1 busy_o)
    else $error("host edge did not take first sample");
  internal_trig_a: assert property (
    (state_reg == OSF_CONV && got_reg == `OSF_ALL_CHANNELS && !last_set)
    |-> ##[1:PACE_MAX] sample_trigger_o)
    else $error("internal trigger missing");
  set_count_a: assert property (
    (state_reg == OSF_CONV && state_next == OSF_OUT)
    |-> trigs_reg == `OSF_SET_W'(set_last + 1'b1))
    else $error("set closed with wrong sample count");
  one_word_a: assert property (
    $fell(busy_o) |-> $past(pch_reg) == `OSF_LAST_CHAN)
    else $error("set ended before all channels");
  hold_result_a: assert property (
    (result_valid_o && !result_ready_i) |=> result_valid_o && $stable(result_data_o))
    else $error("result changed while stalled");
  no_avg_a: assert property (
    (push_v && sel_reg == `OSF_SEL_NONE)
    |-> push_d[`OSF_SAMPLE_W-1:0] == acc_reg[pch_reg][`OSF_SAMPLE_W-1:0])
    else $error("ratio one result differs from sample");
  ratio64_c: cover property (state_reg == OSF_OUT && sel_reg == `OSF_SEL_MAX);
  plain_c: cover property ($fell(busy_o) && sel_reg == `OSF_SEL_NONE);
  fifo_full_c: cover property (push_v && !push_r);
endmodule // osf_filter

// [tb/osf_host_model.sv]
`timescale 1ns/1ns
// converter model: answers each trigger with eight channel samples
module osf_host_model
(
  input wire logic clk_i,
  input wire logic trig_i,
  input wire logic busy_i,
  input wire logic [17:0] base_i,
  input wire logic [3:0] gap_i,
  input wire logic rev_i,
  output logic valid_o,
  output logic [2:0] chan_o,
  output logic [17:0] data_o
);
  int round; // round within the current set
  logic busy_prev = 1'b0; // busy as it stood before the last edge
  // busy before each edge, so that a set's first trigger is told apart
  always @(posedge clk_i)
    busy_prev <= busy_i;
  // sample value for a channel and round
  function automatic logic [17:0] smp(logic [17:0] b, int ch, int r);
    return b + 18'(ch * 'h2F01) - 18'(r * 'h0F3);
  endfunction
  // wait for a trigger, then send one sample per channel back to back
  initial
  begin
    valid_o = 1'b0;
    chan_o = 3'h0;
    data_o = 18'h0;
    round = 0;
    forever
    begin
      @(posedge clk_i);
      #1;
      if (trig_i === 1'b1)
      begin
        // busy is still low just before the first trigger of a set
        round = (busy_prev === 1'b1) ? round + 1 : 0;
        repeat (gap_i + 1) @(posedge clk_i);
        #1;
        for (int i = 0; i < 8; i++)
        begin
          valid_o = 1'b1;
          chan_o = rev_i ? 3'(7 - i) : 3'(i);
          data_o = smp(base_i, chan_o, round);
          @(posedge clk_i);
          #1;
        end
        // released lines never show the last value
        valid_o = 1'b0;
        data_o = ~data_o;
        chan_o = ~chan_o;
      end
    end
  end
endmodule // osf_host_model

// [tb/oversampling_average_filter_bench.sv]
`timescale 1ns/1ns
// bench for the averaging filter
module oversampling_average_filter_bench;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [2:0] sel = 3'h0;
  logic sta = 1'b0;
  logic stb = 1'b0;
  logic ready = 1'b0;
  logic sv;
  logic [2:0] sc;
  logic [17:0] sd;
  logic trig, busy, rv;
  logic [2:0] rc;
  logic [17:0] rd;
  logic [17:0] base = 18'h0;
  logic [3:0] gap = 4'h0;
  logic rev = 1'b0;
  logic stall = 1'b0;
  logic busy_d = 1'b0; // busy at the previous watcher edge
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  int ntrig = 0;
  int since = 0;
  logic [20:0] exp_q[$]; // expected channel and result
  logic [31:0] rs = 32'h2B; // xorshift state
  osf_filter osf_filter_inst (.clk_i(clk_i), .reset_i(reset_i),
    .oversample_ratio_select_i(sel), .group_a_convert_start_i(sta),
    .group_b_convert_start_i(stb), .sample_valid_i(sv), .sample_chan_i(sc),
    .sample_data_i(sd), .result_ready_i(ready), .sample_trigger_o(trig),
    .busy_o(busy), .result_valid_o(rv), .result_chan_o(rc), .result_data_o(rd));
  osf_host_model osf_host_model_inst (.clk_i(clk_i), .trig_i(trig), .busy_i(busy),
    .base_i(base), .gap_i(gap), .rev_i(rev), .valid_o(sv), .chan_o(sc), .data_o(sd));
  // clock source
  initial
  begin
    forever #25 clk_i = ~clk_i;
  end
  // next pseudo random word
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  // verdict and end of run
  task automatic stop_test();
    if (n_mismatch == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // compare one result word
  task automatic chk_res(logic [20:0] e, logic [20:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value result exp %h got %h", e, g);
    end
  endtask
  // compare a flag or count
  task automatic chk_flag(string what, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value %s exp %h got %h", what, e, g);
    end
  endtask
  // reader: random backpressure unless stalled
  always @(posedge clk_i)
  begin
    #1;
    ready = !stall && (xs() % 4 != 0);
  end
  // watcher: triggers, spacing, accepted results, timeout
  always @(negedge clk_i)
  begin
    cyc++;
    since++;
    if (cyc > 20000)
    begin
      n_mismatch++;
      stop_test();
    end
    if (trig === 1'b1)
    begin
      ntrig++;
      // only internal triggers follow a busy cycle
      if (busy_d === 1'b1)
        chk_flag("spacing", 1, since >= 40);
      since = 0;
    end
    busy_d = busy;
    if (rv === 1'b1 && ready === 1'b1)
      chk_res(exp_q.size() ? exp_q.pop_front() : 'x, {rc, rd});
  end
  // one oversampling set, optionally with the reader stalled
  task automatic run_set(logic [2:0] code, logic hold);
    int n0;
    logic signed [23:0] sum;
    logic [23:0] sh;
    logic [17:0] d;
    base = 18'(xs());
    gap = 4'(xs());
    rev = 1'(xs());
    sel = code;
    stall = hold;
    // expected averages, channels in order
    for (int ch = 0; ch < 8; ch++)
    begin
      sum = 0;
      for (int r = 0; r < (1 << code); r++)
      begin
        d = osf_host_model_inst.smp(base, ch, r);
        sum = sum + {{6{d[17]}}, d};
      end
      sh = sum >>> code;
      exp_q.push_back({3'(ch), sh[17:0]});
    end
    // host keeps starts at least a sample period apart
    while (since < 40)
    begin
      @(posedge clk_i);
      #1;
    end
    n0 = ntrig;
    sta = 1'b1;
    stb = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    chk_flag("start", n0 + 1, ntrig);
    // a second edge during the set is ignored
    sta = 1'b0;
    stb = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    sta = 1'b1;
    stb = 1'b1;
    if (hold)
    begin
      repeat (200) @(posedge clk_i);
      #1;
      chk_flag("busy", 1, busy);
      stall = 1'b0;
    end
    for (int i = 0; i < 4000 && busy !== 1'b0; i++)
    begin
      @(posedge clk_i);
      #1;
    end
    chk_flag("triggers", 1 << code, ntrig - n0);
    sta = 1'b0;
    stb = 1'b0;
    for (int i = 0; i < 100 && exp_q.size() > 0; i++)
    begin
      @(posedge clk_i);
      #1;
    end
    chk_flag("drain", 0, exp_q.size());
  endtask
  // main sequence
  initial
  begin
    int n_inv; // triggers seen before the invalid start
    repeat (12) @(posedge clk_i);
    #1;
    chk_flag("reset", 0, {trig, busy, rv});
    reset_i = 1'b0;
    @(posedge clk_i);
    #1;
    // every valid ratio code
    for (int c = 0; c < 7; c++)
      run_set(3'(c), 1'b0);
    // invalid code is refused
    sel = 3'h7;
    n_inv = ntrig;
    sta = 1'b1;
    stb = 1'b1;
    repeat (50) @(posedge clk_i);
    #1;
    chk_flag("invalid", 0, {ntrig != n_inv, busy});
    sta = 1'b0;
    stb = 1'b0;
    @(posedge clk_i);
    #1;
    // reader stalls until the fifo refuses
    run_set(3'h1, 1'b1);
    stop_test();
  end
endmodule // oversampling_average_filter_bench
